// file: cdmp_regs.svh
// Behaviour
// - all port signals timed on rising clk
// - low cycle_extend_enable stretches the bus cycle
// - 32-bit byte address, bursts step by four
// - write_not_read high writes, fixed in burst
// - size codes byte/half/word, never 11
// - bursts are word only, size fixed
// - privilege_indicator zero user, one privileged
// - atomic_lock high only during swap read
// - inverted mode bits, user when forced
// - write data on write bus, coprocessor too
// - read bus sampled at cycle end
// - fault sampled on active cycles, raises abort
// - no path from fault to requests
// - cycle type from request_inactive_n and sequential_flag
// - byte and half writes replicated on bus
`ifndef CDMP_REGS_SVH
`define CDMP_REGS_SVH
// ==========================================
// size codes
`define CDMP_SIZE_BYTE 2'h0
`define CDMP_SIZE_HALF 2'h1
`define CDMP_SIZE_WORD 2'h2
// ==========================================
// cycle type codes {request_inactive_n, sequential_flag}
`define CDMP_CYC_N 2'h0
`define CDMP_CYC_S 2'h1
`define CDMP_CYC_I 2'h2
`define CDMP_CYC_C 2'h3
// ==========================================
// misc constants
`define CDMP_WORD_STEP 32'h00000004
`define CDMP_MODE_USER 5'h10
`define CDMP_MODE_SVC 5'h13
`endif

// file: cdmp_pkg.sv
package cdmp_pkg;
    // request kinds from the core pipeline
    typedef enum logic [1:0] {CDMP_OP_NONE, CDMP_OP_LOAD, CDMP_OP_STORE, CDMP_OP_COPRO} cdmp_op_t;
    // port sequencer states
    typedef enum logic [1:0] {CDMP_IDLE, CDMP_XFER, CDMP_SWAP_WR} cdmp_state_t;
endpackage : cdmp_pkg

// file: cdmp_port.sv
`timescale 1ns/1ps
`include "cdmp_regs.svh"
// ==========================================
// data memory port of the core: takes requests from the pipeline side,
// drives the pipelined address and request signals, returns read data
module cdmp_port
    import cdmp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    // far side
    input wire logic cycle_extend_enable,
    input wire logic [31:0] read_data_in,
    input wire logic access_fault,
    output logic [31:0] data_byte_address,
    output logic write_not_read,
    output logic [1:0] transfer_size,
    output logic privilege_indicator,
    output logic atomic_lock,
    output logic [4:0] inverted_mode_bits,
    output logic request_inactive_n,
    output logic sequential_flag,
    output logic more_requests_hint,
    output logic [31:0] write_data_out,
    // core side
    input wire logic req_valid,
    input wire cdmp_op_t req_op,
    input wire logic [31:0] req_addr,
    input wire logic [1:0] req_size,
    input wire logic [31:0] req_wdata,
    input wire logic [3:0] req_beats,
    input wire logic req_swap,
    input wire logic req_force_user,
    input wire logic [4:0] program_status_mode,
    output logic req_ready,
    output logic [31:0] rsp_rdata,
    output logic rsp_valid,
    output logic data_abort
);
    // ==========================================
    // far-side inputs: the memory side is clocked by this same edge, so the
    // enable, fault and read bus are used as they stand; a two-flop stage here
    // would land read data and fault two cycles after their bus cycle ended
    // and the stretch enable would act two cycles too late
    logic ext_en; // a step is allowed at this edge
    logic fault_in; // fault for the data phase now ending
    logic [31:0] rd_in; // read bus for the data phase now ending
    assign ext_en = cycle_extend_enable;
    assign fault_in = access_fault;
    assign rd_in = read_data_in;

    // replicate narrow store data over all lanes
    function automatic logic [31:0] replicate(input logic [1:0] sz, input logic [31:0] d);
        begin
            if (sz == `CDMP_SIZE_BYTE)
                replicate = {4{d[7:0]}};
            else if (sz == `CDMP_SIZE_HALF)
                replicate = {2{d[15:0]}};
            else
                replicate = d;
        end
    endfunction : replicate

    // ==========================================
    // sequencer state
    cdmp_state_t st_r, st_nxt; // sequencer state
    logic [31:0] addr_r, addr_nxt; // address bus
    logic wnr_r, wnr_nxt; // direction
    logic [1:0] size_r, size_nxt; // transfer size
    logic priv_r, priv_nxt; // privilege
    logic lock_r, lock_nxt; // atomic lock
    logic [4:0] nmode_r, nmode_nxt; // inverted mode
    logic nreq_r, nreq_nxt; // request inactive
    logic seq_r, seq_nxt; // sequential flag
    logic more_r, more_nxt; // hint
    logic [31:0] wd_r, wd_nxt; // write bus
    logic [3:0] left_r, left_nxt; // beats still to issue
    logic [31:0] swapd_r, swapd_nxt; // swap write data held
    logic act_r, act_nxt; // a cycle was presented last step
    logic dph_r, dph_nxt; // an n or s data phase is running
    logic dwr_r, dwr_nxt; // that data phase is a write
    logic [31:0] rsp_r, rsp_nxt; // read result
    logic rspv_r, rspv_nxt; // read result strobe
    logic abt_r, abt_nxt; // abort strobe
    logic rdy_r, rdy_nxt; // can take a request

    // ==========================================
    // next state; everything but the read and abort strobes advances only on an enabled step
    always_comb
    begin
        st_nxt = st_r;
        addr_nxt = addr_r;
        wnr_nxt = wnr_r;
        size_nxt = size_r;
        priv_nxt = priv_r;
        lock_nxt = lock_r;
        nmode_nxt = nmode_r;
        nreq_nxt = nreq_r;
        seq_nxt = seq_r;
        more_nxt = more_r;
        wd_nxt = wd_r;
        left_nxt = left_r;
        swapd_nxt = swapd_r;
        act_nxt = act_r;
        dph_nxt = dph_r;
        dwr_nxt = dwr_r;
        rsp_nxt = rsp_r;
        rspv_nxt = 1'b0;
        abt_nxt = 1'b0;
        rdy_nxt = rdy_r;
        if (ext_en)
        begin
            // end of a data phase: capture data and fault for the phase just ended
            if (dph_r && !dwr_r)
            begin
                rsp_nxt = rd_in;
                rspv_nxt = 1'b1;
            end
            // only n and s cycles look at the fault input
            abt_nxt = dph_r && fault_in;
            // the pipelined request presented last step now enters its data phase
            dph_nxt = act_r;
            dwr_nxt = wnr_r;
            act_nxt = 1'b0;
            case (st_r)
                CDMP_IDLE:
                begin
                    nreq_nxt = 1'b1;
                    seq_nxt = 1'b0;
                    more_nxt = 1'b0;
                    lock_nxt = 1'b0;
                    rdy_nxt = 1'b1;
                    if (req_valid && rdy_r && req_op != CDMP_OP_NONE)
                    begin
                        rdy_nxt = 1'b0;
                        addr_nxt = req_addr;
                        // bursts are forced to word size, reserved code never leaves
                        size_nxt = (req_beats > 4'h1 || req_size == 2'h3) ? `CDMP_SIZE_WORD
                            : req_size;
                        priv_nxt = !req_force_user && (program_status_mode != `CDMP_MODE_USER);
                        nmode_nxt = req_force_user ? ~`CDMP_MODE_USER : ~program_status_mode;
                        wnr_nxt = (req_op == CDMP_OP_STORE) && !req_swap;
                        wd_nxt = replicate(req_size, req_wdata);
                        swapd_nxt = req_wdata;
                        lock_nxt = req_swap && (req_op != CDMP_OP_COPRO);
                        if (req_op == CDMP_OP_COPRO)
                        begin
                            {nreq_nxt, seq_nxt} = `CDMP_CYC_C;
                            act_nxt = 1'b0;
                            left_nxt = 4'h0;
                            st_nxt = CDMP_IDLE;
                        end
                        else
                        begin
                            {nreq_nxt, seq_nxt} = `CDMP_CYC_N;
                            act_nxt = 1'b1;
                            left_nxt = (req_beats == 4'h0) ? 4'h0 : req_beats - 4'h1;
                            more_nxt = req_beats > 4'h1;
                            st_nxt = req_swap ? CDMP_SWAP_WR : CDMP_XFER;
                        end
                    end
                end
                CDMP_XFER:
                begin
                    act_nxt = 1'b1;
                    if (left_r != 4'h0)
                    begin
                        // the fault never feeds this choice, so a request may follow an abort
                        addr_nxt = addr_r + `CDMP_WORD_STEP;
                        {nreq_nxt, seq_nxt} = `CDMP_CYC_S;
                        left_nxt = left_r - 4'h1;
                        more_nxt = left_r > 4'h1;
                    end
                    else
                    begin
                        act_nxt = 1'b0;
                        {nreq_nxt, seq_nxt} = `CDMP_CYC_I;
                        more_nxt = 1'b0;
                        lock_nxt = 1'b0;
                        rdy_nxt = 1'b1;
                        st_nxt = CDMP_IDLE;
                    end
                end
                CDMP_SWAP_WR:
                begin
                    // second half of an atomic swap: write to same address, lock dropped
                    act_nxt = 1'b1;
                    {nreq_nxt, seq_nxt} = `CDMP_CYC_N;
                    wnr_nxt = 1'b1;
                    wd_nxt = replicate(size_r, swapd_r);
                    lock_nxt = 1'b0;
                    left_nxt = 4'h0;
                    st_nxt = CDMP_XFER;
                end
                default:
                begin
                    st_nxt = CDMP_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // registers, launched on the rising edge
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_r <= CDMP_IDLE;
            addr_r <= 32'h0;
            wnr_r <= 1'b0;
            size_r <= `CDMP_SIZE_WORD;
            priv_r <= 1'b1;
            lock_r <= 1'b0;
            nmode_r <= ~`CDMP_MODE_SVC;
            nreq_r <= 1'b1;
            seq_r <= 1'b0;
            more_r <= 1'b0;
            wd_r <= 32'h0;
            left_r <= 4'h0;
            swapd_r <= 32'h0;
            act_r <= 1'b0;
            dph_r <= 1'b0;
            dwr_r <= 1'b0;
            rsp_r <= 32'h0;
            rspv_r <= 1'b0;
            abt_r <= 1'b0;
            rdy_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            addr_r <= addr_nxt;
            wnr_r <= wnr_nxt;
            size_r <= size_nxt;
            priv_r <= priv_nxt;
            lock_r <= lock_nxt;
            nmode_r <= nmode_nxt;
            nreq_r <= nreq_nxt;
            seq_r <= seq_nxt;
            more_r <= more_nxt;
            wd_r <= wd_nxt;
            left_r <= left_nxt;
            swapd_r <= swapd_nxt;
            act_r <= act_nxt;
            dph_r <= dph_nxt;
            dwr_r <= dwr_nxt;
            rsp_r <= rsp_nxt;
            rspv_r <= rspv_nxt;
            abt_r <= abt_nxt;
            rdy_r <= rdy_nxt;
        end
    end

    // outputs straight from flops
    assign data_byte_address = addr_r;
    assign write_not_read = wnr_r;
    assign transfer_size = size_r;
    assign privilege_indicator = priv_r;
    assign atomic_lock = lock_r;
    assign inverted_mode_bits = nmode_r;
    assign request_inactive_n = nreq_r;
    assign sequential_flag = seq_r;
    assign more_requests_hint = more_r;
    assign write_data_out = wd_r;
    assign req_ready = rdy_r;
    assign rsp_rdata = rsp_r;
    assign rsp_valid = rspv_r;
    assign data_abort = abt_r;

    // ==========================================
    // checks
    AST_SIZE_LEGAL: assert property (@(posedge clk) disable iff (rst)
        transfer_size != 2'h3) else $error("reserved size driven");
    AST_SEQ_WORD: assert property (@(posedge clk) disable iff (rst)
        (!request_inactive_n && sequential_flag) |-> transfer_size == `CDMP_SIZE_WORD)
        else $error("non-word burst");
    AST_SEQ_STEP: assert property (@(posedge clk) disable iff (rst)
        (!request_inactive_n && sequential_flag && $changed(data_byte_address))
        |-> data_byte_address == $past(data_byte_address) + 32'h4)
        else $error("burst address step wrong");
    AST_SEQ_DIR: assert property (@(posedge clk) disable iff (rst)
        (!request_inactive_n && sequential_flag) |-> $stable(write_not_read))
        else $error("direction changed in burst");
    AST_REPL: assert property (@(posedge clk) disable iff (rst)
        (write_not_read && transfer_size == `CDMP_SIZE_BYTE && !request_inactive_n)
        |-> write_data_out[31:24] == write_data_out[7:0])
        else $error("byte not replicated");
    AST_ABORT: assert property (@(posedge clk) disable iff (rst)
        (ext_en && dph_r && fault_in) |=> data_abort)
        else $error("abort lost");
    AST_NO_ABORT_IDLE: assert property (@(posedge clk) disable iff (rst)
        (ext_en && !dph_r) |=> !data_abort)
        else $error("abort outside active cycle");
    AST_LOCK_SWAP: assert property (@(posedge clk) disable iff (rst)
        (atomic_lock && ext_en) |-> !write_not_read ##1
        (!atomic_lock && write_not_read && !request_inactive_n))
        else $error("lock outside swap read");
    AST_STALL: assert property (@(posedge clk) disable iff (rst)
        !ext_en |=> $stable(data_byte_address) && $stable(request_inactive_n))
        else $error("moved while stretched");
    AST_MODE: assert property (@(posedge clk) disable iff (rst)
        (!request_inactive_n && !privilege_indicator) |-> inverted_mode_bits == ~`CDMP_MODE_USER)
        else $error("user access without user mode");
    COV_BURST: cover property (@(posedge clk) disable iff (rst)
        !request_inactive_n && sequential_flag ##1 sequential_flag);
    COV_SWAP: cover property (@(posedge clk) disable iff (rst) $rose(atomic_lock));
    COV_ABORT: cover property (@(posedge clk) disable iff (rst) data_abort);
    COV_STRETCH: cover property (@(posedge clk) disable iff (rst) !ext_en ##1 ext_en);
endmodule : cdmp_port

// file: cdmp_mem_model.sv
`timescale 1ns/1ps
// ==========================================
// far-side memory: 16 words, byte lanes, optional stall and fault
// single master here, so a locked pair is never split
module cdmp_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic fault_en,
    input wire logic [31:0] fault_addr,
    input wire logic [31:0] data_byte_address,
    input wire logic write_not_read,
    input wire logic [1:0] transfer_size,
    input wire logic request_inactive_n,
    input wire logic [31:0] write_data_out,
    output logic cycle_extend_enable,
    output logic [31:0] read_data_in,
    output logic access_fault
);
    logic [31:0] mem [16]; // word store
    logic wr_pend; // a write waits for its data edge
    logic [31:0] wr_a; // address of that write
    logic [1:0] wr_sz; // size of that write
    initial
    begin
        for (int k = 0; k < 16; k++)
            mem[k] = 32'h01010101 * k;
    end
    // act only on edges where the enable is high, the same edges the core steps on,
    // so a frozen cycle is not doubled
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cycle_extend_enable <= 1'b1;
            wr_pend <= 1'b0;
            access_fault <= 1'b0;
            read_data_in <= 32'h0;
        end
        else
        begin
            cycle_extend_enable <= slow ? ~cycle_extend_enable : 1'b1;
            if (cycle_extend_enable)
            begin
                // write data taken at the edge ending the write cycle
                if (wr_pend)
                begin
                    if (wr_sz == 2'h0)
                        mem[wr_a[5:2]][8*wr_a[1:0] +: 8] <= write_data_out[8*wr_a[1:0] +: 8];
                    else if (wr_sz == 2'h1)
                        mem[wr_a[5:2]][16*wr_a[1] +: 16] <= write_data_out[16*wr_a[1] +: 16];
                    else
                        mem[wr_a[5:2]] <= write_data_out;
                end
                wr_pend <= 1'b0;
                access_fault <= 1'b0;
                // released bus shows the inverse so stale data cannot pass
                read_data_in <= ~read_data_in;
                // commit on N or S only, and never on an aborted cycle's request
                if (!request_inactive_n && !access_fault)
                begin
                    if (fault_en && data_byte_address == fault_addr)
                        access_fault <= 1'b1;
                    else if (write_not_read)
                        wr_pend <= 1'b1;
                    else
                        read_data_in <= mem[data_byte_address[5:2]];
                    wr_a <= data_byte_address;
                    wr_sz <= transfer_size;
                end
            end
        end
    end
endmodule : cdmp_mem_model

// file: testbench.sv
`timescale 1ns/1ps
`include "cdmp_regs.svh"
// ==========================================
// directed bench: pipeline-side requests against the memory model
module testbench;
    import cdmp_pkg::*;
    logic clk, rst, slow, fault_en, cycle_extend_enable, access_fault;
    logic [31:0] fault_addr, read_data_in, data_byte_address, write_data_out;
    logic write_not_read, privilege_indicator, atomic_lock, request_inactive_n;
    logic sequential_flag, more_requests_hint, req_valid, req_swap, req_force_user;
    logic req_ready, rsp_valid, data_abort;
    logic [1:0] transfer_size, req_size;
    logic [4:0] inverted_mode_bits, program_status_mode;
    logic [31:0] req_addr, req_wdata, rsp_rdata;
    logic [3:0] req_beats;
    cdmp_op_t req_op;
    logic [31:0] exp_mem [16]; // expected memory image
    int error_cnt, check_count;
    cdmp_port DUT (.clk, .rst, .cycle_extend_enable, .read_data_in, .access_fault,
        .data_byte_address, .write_not_read, .transfer_size, .privilege_indicator,
        .atomic_lock, .inverted_mode_bits, .request_inactive_n, .sequential_flag,
        .more_requests_hint, .write_data_out, .req_valid, .req_op, .req_addr, .req_size,
        .req_wdata, .req_beats, .req_swap, .req_force_user, .program_status_mode,
        .req_ready, .rsp_rdata, .rsp_valid, .data_abort);
    cdmp_mem_model MEM (.clk, .rst, .slow, .fault_en, .fault_addr, .data_byte_address,
        .write_not_read, .transfer_size, .request_inactive_n, .write_data_out,
        .cycle_extend_enable, .read_data_in, .access_fault);
    always #12.5 clk = ~clk;
    task automatic final_report;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one clock, sampled after it settles; a hang counts as a mismatch
    task automatic step(inout int t);
        @(posedge clk);
        #1;
        t++;
        if (t > 400)
        begin
            chk(32'h0, 32'h1);
            final_report();
        end
    endtask : step
    // byte lanes of the expected image
    task automatic put(input logic [31:0] a, input logic [1:0] sz, input logic [31:0] wd);
        if (sz == 2'h0)
            exp_mem[a[5:2]][8*a[1:0] +: 8] = wd[7:0];
        else if (sz == 2'h1)
            exp_mem[a[5:2]][16*a[1] +: 16] = wd[15:0];
        else
            exp_mem[a[5:2]] = wd;
    endtask : put
    // one request, its first address phase checked, then every response
    task automatic xfer(input cdmp_op_t op, input logic [31:0] a, input logic [1:0] sz,
        input logic [31:0] wd, input logic [3:0] nb, input logic sw, input logic fu,
        input logic ab);
        int t;
        logic [31:0] old;
        logic [4:0] md;
        t = 0;
        old = exp_mem[a[5:2]];
        while (req_ready !== 1'b1)
            step(t);
        @(posedge clk);
        // mode read here, after any change made just before the call has landed
        md = fu ? `CDMP_MODE_USER : program_status_mode;
        req_valid <= 1'b1;
        req_op <= op;
        req_addr <= a;
        req_size <= sz;
        req_wdata <= wd;
        req_beats <= nb;
        req_swap <= sw;
        req_force_user <= fu;
        do
            step(t);
        while (req_ready === 1'b1);
        chk({request_inactive_n, sequential_flag}, op == CDMP_OP_COPRO ? 2'h3 : 2'h0);
        if (op != CDMP_OP_COPRO)
        begin
            chk(data_byte_address, a);
            chk(write_not_read, op == CDMP_OP_STORE);
            chk(transfer_size, sz == 2'h3 ? 2'h2 : sz);
            chk(privilege_indicator, md != `CDMP_MODE_USER);
            chk(inverted_mode_bits, md ^ 5'h1f);
            chk(atomic_lock, sw);
            chk(more_requests_hint, nb > 4'h1);
            if (op == CDMP_OP_STORE)
                chk(write_data_out, sz == 2'h0 ? {4{wd[7:0]}} : sz == 2'h1 ? {2{wd[15:0]}} : wd);
        end
        @(posedge clk);
        req_valid <= 1'b0;
        #1;
        if (op == CDMP_OP_STORE || sw)
            put(a, sz, wd);
        if (op == CDMP_OP_COPRO)
            return;
        // only loads answer; a swap answers once, for its read half
        for (int k = 0; k < ((op == CDMP_OP_LOAD) ? nb : 4'h0); k++)
        begin
            while (rsp_valid !== 1'b1 && data_abort !== 1'b1)
                step(t);
            chk(data_abort, ab);
            if (op == CDMP_OP_LOAD && !ab && k < nb)
                chk(rsp_rdata, sw ? old : exp_mem[a[5:2] + k]);
            step(t);
        end
    endtask : xfer
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        slow = 1'b0;
        fault_en = 1'b0;
        fault_addr = 32'h14;
        req_valid = 1'b0;
        req_op = CDMP_OP_NONE;
        req_addr = 32'h0;
        req_size = 2'h2;
        req_wdata = 32'h0;
        req_beats = 4'h1;
        req_swap = 1'b0;
        req_force_user = 1'b0;
        program_status_mode = `CDMP_MODE_SVC;
        error_cnt = 0;
        check_count = 0;
        for (int k = 0; k < 16; k++)
            exp_mem[k] = 32'h01010101 * k;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 4; k++)
            xfer(CDMP_OP_STORE, 32'h10 + 4 * k, 2'h2, 32'hc0de0000 + k, 4'h1, 0, 0, 0);
        xfer(CDMP_OP_STORE, 32'h11, 2'h0, 32'h1234565a, 4'h1, 0, 0, 0);
        xfer(CDMP_OP_STORE, 32'h1a, 2'h1, 32'h9876beef, 4'h1, 0, 0, 0);
        xfer(CDMP_OP_LOAD, 32'h10, 2'h2, 32'h0, 4'h4, 0, 0, 0);
        xfer(CDMP_OP_LOAD, 32'h14, 2'h3, 32'h0, 4'h1, 0, 1, 0);
        @(posedge clk);
        program_status_mode <= `CDMP_MODE_USER;
        xfer(CDMP_OP_LOAD, 32'h20, 2'h2, 32'h0, 4'h1, 0, 0, 0);
        @(posedge clk);
        program_status_mode <= `CDMP_MODE_SVC;
        xfer(CDMP_OP_LOAD, 32'h18, 2'h2, 32'h5aa5f00f, 4'h1, 1, 0, 0);
        xfer(CDMP_OP_LOAD, 32'h18, 2'h2, 32'h0, 4'h1, 0, 0, 0);
        @(posedge clk);
        fault_en <= 1'b1;
        xfer(CDMP_OP_LOAD, 32'h14, 2'h2, 32'h0, 4'h1, 0, 0, 1);
        @(posedge clk);
        fault_en <= 1'b0;
        xfer(CDMP_OP_LOAD, 32'h10, 2'h2, 32'h0, 4'h1, 0, 0, 0);
        @(posedge clk);
        slow <= 1'b1;
        xfer(CDMP_OP_LOAD, 32'h18, 2'h2, 32'h0, 4'h2, 0, 0, 0);
        @(posedge clk);
        slow <= 1'b0;
        xfer(CDMP_OP_COPRO, 32'h0, 2'h2, 32'h0, 4'h1, 0, 0, 0);
        xfer(CDMP_OP_LOAD, 32'h10, 2'h2, 32'h0, 4'h4, 0, 0, 0);
        repeat (10) @(posedge clk);
        final_report();
    end
endmodule : testbench
